// ==== logic/fse_status_regs.sv ====
// Purpose: Flash command status, ECC error status and error irq enables.
// Assumes: Event inputs are one-cycle pulses synchronous to sys_clk.
// Notes: Command engine, protection decode and ECC logic live outside.
`timescale 1ns/1ps
module fse_status_regs #(
   parameter int ADDR_W = fse_pkg::FSE_ADDR_W
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmd_done,
   input wire logic [1:0] cmd_done_status,
   input wire logic seq_violation,
   input wire logic illegal_cmd,
   input wire logic prot_violation,
   input wire logic seq_start_req,
   input wire logic reset_seq_done,
   input wire logic reset_seq_double_fault,
   input wire logic array_read,
   input wire logic ecc_single_fault,
   input wire logic ecc_double_fault,
   input wire logic read_collision,
   output logic cmd_launch,
   output logic seq_start_ok,
   output logic command_irq,
   output logic error_irq
);
   // ***************************************************************
   // Bus decode
   // ***************************************************************
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic [7:0] reg_index;
   logic [7:0] wr_byte;
   logic sel_cfg;
   logic sel_err_en;
   logic sel_cmd;
   logic sel_ecc;

   fse_apb_slave #(
      .ADDR_W(ADDR_W)
   ) u_apb (
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .pready(pready),
      .pslverr(pslverr),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .reg_index(reg_index),
      .wr_byte(wr_byte),
      .mapped(mapped)
   );

   // Word aligned addresses only; low bits must be zero.
   assign sel_cfg = (reg_index == fse_pkg::FSE_IDX_FLASH_CFG);
   assign sel_err_en = (reg_index == fse_pkg::FSE_IDX_ERR_IRQ_EN);
   assign sel_cmd = (reg_index == fse_pkg::FSE_IDX_CMD_STATUS);
   assign sel_ecc = (reg_index == fse_pkg::FSE_IDX_ECC_STATUS);
   assign mapped = (paddr[1:0] == 2'h0) &
                   ((reg_index >> 8) == 8'h00) &
                   (sel_cfg | sel_err_en | sel_cmd | sel_ecc);

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   logic [7:0] flash_configuration_reg;
   logic [7:0] error_irq_enable_reg;

   // Only the enable, ignore and force bits of the configuration exist.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         flash_configuration_reg <= fse_pkg::FSE_RST_ZERO;
      else if (wr_en & sel_cfg)
         flash_configuration_reg <= wr_byte & fse_pkg::FSE_CFG_MASK;
   end

   // Two enable bits; the upper six never store a value.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         error_irq_enable_reg <= fse_pkg::FSE_RST_ZERO;
      else if (wr_en & sel_err_en)
         error_irq_enable_reg <= wr_byte &
                                 fse_pkg::FSE_ERR_IRQ_EN_MASK;
   end

   logic command_complete_irq_en;
   logic ignore_single_fault;
   logic force_double_fault;
   logic double_fault_irq_en;
   logic single_fault_irq_en;
   assign command_complete_irq_en =
      flash_configuration_reg[fse_pkg::FSE_CC_IE_BIT];
   assign ignore_single_fault =
      flash_configuration_reg[fse_pkg::FSE_IGN_SF_BIT];
   assign force_double_fault =
      flash_configuration_reg[fse_pkg::FSE_FORCE_DF_BIT];
   assign double_fault_irq_en = error_irq_enable_reg[fse_pkg::FSE_DF_IE_BIT];
   assign single_fault_irq_en = error_irq_enable_reg[fse_pkg::FSE_SF_IE_BIT];

   // ***************************************************************
   // Command status
   // ***************************************************************
   logic access_error_flag;
   logic protection_violation_flag;
   logic command_complete_flag_reg;
   logic [1:0] completion_status_reg;
   logic cmd_wr;
   logic acc_set;
   logic pv_set;

   assign cmd_wr = wr_en & sel_cmd;
   // A launch needs both error flags clear; a write of one is ignored else.
   assign cmd_launch = cmd_wr & wr_byte[fse_pkg::FSE_CCF_BIT] &
                       command_complete_flag_reg &
                       ~access_error_flag &
                       ~protection_violation_flag;
   assign seq_start_ok = seq_start_req &
                         ~protection_violation_flag;
   assign acc_set = seq_violation | illegal_cmd;
   assign pv_set = prot_violation;

   // Flag drops at launch and rises at completion or a violation.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         command_complete_flag_reg <= 1'b1;
      else if (cmd_done | acc_set | pv_set)
         command_complete_flag_reg <= 1'b1;
      else if (cmd_launch)
         command_complete_flag_reg <= 1'b0;
   end

   fse_w1c_flag u_acc (
      .sys_clk(sys_clk),
      .reset(reset),
      .set_pulse(acc_set),
      .clear_pulse(cmd_wr & wr_byte[fse_pkg::FSE_ACC_BIT]),
      .flag_reg(access_error_flag)
   );

   fse_w1c_flag u_pv (
      .sys_clk(sys_clk),
      .reset(reset),
      .set_pulse(pv_set),
      .clear_pulse(cmd_wr & wr_byte[fse_pkg::FSE_PV_BIT]),
      .flag_reg(protection_violation_flag)
   );

   // Status clears at each launch and loads the result at completion.
   // A double fault in the reset sequence leaves both status bits set.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         completion_status_reg <= fse_pkg::FSE_STAT_CLEAN;
      else if (reset_seq_done & reset_seq_double_fault)
         completion_status_reg <= fse_pkg::FSE_STAT_RESET_DF;
      else if (cmd_done)
         completion_status_reg <= cmd_done_status;
      else if (cmd_launch)
         completion_status_reg <= fse_pkg::FSE_STAT_CLEAN;
   end

   logic [7:0] command_status;
   // Busy mirrors an open command; bit two and others are constant zero.
   always_comb
   begin
      command_status = fse_pkg::FSE_RST_ZERO;
      command_status[fse_pkg::FSE_CCF_BIT] = command_complete_flag_reg;
      command_status[fse_pkg::FSE_ACC_BIT] = access_error_flag;
      command_status[fse_pkg::FSE_PV_BIT] = protection_violation_flag;
      command_status[fse_pkg::FSE_BUSY_BIT] =
         ~command_complete_flag_reg;
      command_status[1:0] = completion_status_reg;
   end

   // ***************************************************************
   // ECC error status
   // ***************************************************************
   logic single_fault_flag;
   logic double_fault_flag;
   logic sf_set;
   logic df_set;
   logic ecc_wr;

   assign ecc_wr = wr_en & sel_ecc;
   // A real double fault excludes the single report; collision sets both.
   assign df_set = ecc_double_fault | read_collision |
                   (array_read & force_double_fault);
   assign sf_set = read_collision |
                   (ecc_single_fault & ~ecc_double_fault &
                    ~ignore_single_fault);

   fse_w1c_flag u_df (
      .sys_clk(sys_clk),
      .reset(reset),
      .set_pulse(df_set),
      .clear_pulse(ecc_wr & wr_byte[fse_pkg::FSE_DF_BIT]),
      .flag_reg(double_fault_flag)
   );

   fse_w1c_flag u_sf (
      .sys_clk(sys_clk),
      .reset(reset),
      .set_pulse(sf_set),
      .clear_pulse(ecc_wr & wr_byte[fse_pkg::FSE_SF_BIT]),
      .flag_reg(single_fault_flag)
   );

   logic [7:0] ecc_error_status;
   always_comb
   begin
      ecc_error_status = fse_pkg::FSE_RST_ZERO;
      ecc_error_status[fse_pkg::FSE_DF_BIT] = double_fault_flag;
      ecc_error_status[fse_pkg::FSE_SF_BIT] = single_fault_flag;
   end

   // ***************************************************************
   // Interrupt requests and read data
   // ***************************************************************
   // Levels straight from flags and enables, so they follow a clear at once.
   assign command_irq = command_complete_flag_reg &
                        command_complete_irq_en;
   assign error_irq = (double_fault_flag & double_fault_irq_en) |
                      (single_fault_flag & single_fault_irq_en);

   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = fse_pkg::FSE_RST_ZERO;
      if (sel_cfg)
         rd_mux = flash_configuration_reg;
      else if (sel_err_en)
         rd_mux = error_irq_enable_reg;
      else if (sel_cmd)
         rd_mux = command_status;
      else if (sel_ecc)
         rd_mux = ecc_error_status;
   end

   // Read data is registered; it is held from the setup edge.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         prdata <= fse_pkg::FSE_READ_ZERO;
      else if (psel & ~penable & ~pwrite)
         prdata <= {24'h000000, rd_mux};
      else if (~psel)
         prdata <= fse_pkg::FSE_READ_ZERO;
   end
   logic rd_unused;
   assign rd_unused = rd_en;
endmodule

// ==== logic/fse_pkg.sv ====
// Purpose: Constants shared by the flash status and error register bank.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Printed offsets are not all multiples of four, so each is an index.
package fse_pkg;
   // ***************************************************************
   // Register indices and widths
   // ***************************************************************
   localparam logic [7:0] FSE_IDX_FLASH_CFG = 8'h04;
   localparam logic [7:0] FSE_IDX_ERR_IRQ_EN = 8'h05;
   localparam logic [7:0] FSE_IDX_CMD_STATUS = 8'h06;
   localparam logic [7:0] FSE_IDX_ECC_STATUS = 8'h07;
   localparam int FSE_ADDR_W = 12;
   localparam int FSE_REG_W = 8;
   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int FSE_SF_IE_BIT = 0;
   localparam int FSE_DF_IE_BIT = 1;
   localparam int FSE_CC_IE_BIT = 7;
   localparam int FSE_IGN_SF_BIT = 4;
   localparam int FSE_FORCE_DF_BIT = 1;
   localparam int FSE_CCF_BIT = 7;
   localparam int FSE_ACC_BIT = 5;
   localparam int FSE_PV_BIT = 4;
   localparam int FSE_BUSY_BIT = 3;
   localparam int FSE_SF_BIT = 0;
   localparam int FSE_DF_BIT = 1;
   // ***************************************************************
   // Reset values and masks
   // ***************************************************************
   localparam logic [7:0] FSE_ERR_IRQ_EN_MASK = 8'h03;
   localparam logic [7:0] FSE_CFG_MASK = 8'h92;
   localparam logic [7:0] FSE_RST_ZERO = 8'h00;
   localparam logic [1:0] FSE_STAT_CLEAN = 2'h0;
   localparam logic [1:0] FSE_STAT_RESET_DF = 2'h3;
   localparam logic [31:0] FSE_READ_ZERO = 32'h0000_0000;
endpackage

// ==== logic/fse_w1c_flag.sv ====
// Purpose: One sticky flag that hardware sets and software clears by one.
// Assumes: Synchronous active high reset.
// Notes: A set in the same cycle as a clear wins.
`timescale 1ns/1ps
module fse_w1c_flag #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic set_pulse,
   input wire logic clear_pulse,
   output logic flag_reg
);
   // Set dominates so no event is lost under a racing clear.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         flag_reg <= RESET_VAL;
      else if (set_pulse)
         flag_reg <= 1'b1;
      else if (clear_pulse)
         flag_reg <= 1'b0;
   end
endmodule

// ==== logic/fse_apb_slave.sv ====
// Purpose: APB slave front end: decodes one access, answers with no wait.
// Assumes: 32-bit APB, registers in the low byte of aligned words.
// Notes: Unmapped indices read zero and signal pslverr; paddr bits above bit 9 are not decoded, so those addresses alias.
`timescale 1ns/1ps
module fse_apb_slave #(
   parameter int ADDR_W = 12
) (
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] reg_index,
   output logic [7:0] wr_byte,
   input wire logic mapped
);
   // Access phase completes in its first cycle; writes need lane zero.
   assign pready = 1'b1;
   assign reg_index = 8'(paddr >> 2);
   assign wr_byte = pwdata[7:0];
   assign wr_en = psel & penable & pwrite & mapped & pstrb[0];
   assign rd_en = psel & penable & ~pwrite & mapped;
   assign pslverr = psel & penable & ~mapped;
endmodule

// ==== test/fse_status_regs_sva.sv ====
// Purpose: Port checks for the flash status and error register bank.
// Assumes: Synchronous active high reset, zero wait APB slave.
// Notes: Internal flags are hidden, so checks tie outputs to events.
`timescale 1ns/1ps
module fse_status_regs_sva #(
   parameter int ADDR_W = 12
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic seq_violation,
   input wire logic illegal_cmd,
   input wire logic prot_violation,
   input wire logic seq_start_req,
   input wire logic cmd_launch,
   input wire logic seq_start_ok,
   input wire logic command_irq,
   input wire logic error_irq
);
   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Access phase and the status word address each recur in four of the nine checks.
   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_pv_then_req;
      prot_violation ##1 seq_start_req;
   endsequence
   logic st_hit;
   assign st_hit = paddr == ADDR_W'(8'h18);
   property p_ready;
      s_acc |-> pready;
   endproperty
   property p_launch_cause;
      cmd_launch |-> psel && penable && pwrite && pwdata[7] && pstrb[0]
         && st_hit;
   endproperty
   // A clearing write within the window may legally reopen launches.
   property p_acc_block;
      seq_violation || illegal_cmd |=>
         (!cmd_launch || (pwrite && st_hit && pwdata[5])) [*8];
   endproperty
   property p_pv_block;
      prot_violation |=>
         (!cmd_launch || (pwrite && st_hit && pwdata[4])) [*8];
   endproperty
   property p_seq_block;
      s_pv_then_req |-> !seq_start_ok;
   endproperty
   property p_stat_bits;
      s_acc and !pwrite && st_hit |-> !prdata[2] && prdata[31:8] == 24'h0;
   endproperty
   property p_en_bits;
      s_acc and !pwrite && paddr == ADDR_W'(8'h14) |-> prdata[7:2] == 6'h0;
   endproperty
   property p_unmapped;
      s_acc and paddr == ADDR_W'(8'hfc) |-> pslverr && prdata == 32'h0;
   endproperty
   property p_reset_quiet;
      $fell(reset) |-> !error_irq && !command_irq;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   a_launch_cause: assert property (p_launch_cause)
      else $error("launch without a launching write");
   a_acc_block: assert property (p_acc_block)
      else $error("launch while access error set");
   a_pv_block: assert property (p_pv_block)
      else $error("launch while protection violation set");
   a_seq_block: assert property (p_seq_block)
      else $error("sequence start allowed after violation");
   a_stat_bits: assert property (p_stat_bits)
      else $error("status reserved bits not zero");
   a_en_bits: assert property (p_en_bits)
      else $error("enable reserved bits not zero");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("interrupt active after reset");
endmodule
bind fse_status_regs fse_status_regs_sva #(.ADDR_W(ADDR_W)) u_sva (
   .sys_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .seq_violation, .illegal_cmd,
   .prot_violation, .seq_start_req, .cmd_launch, .seq_start_ok,
   .command_irq, .error_irq);

// ==== test/fse_status_regs_test.sv ====
// Purpose: Self-checking bench for the flash status and error bank.
// Assumes: Zero wait APB slave, event inputs pulsed for one cycle.
// Notes: Reads queue their expected byte and a monitor compares them.
`timescale 1ns/1ps
module fse_status_regs_test;
   localparam logic [7:0] CFG = fse_pkg::FSE_IDX_FLASH_CFG;
   localparam logic [7:0] EN = fse_pkg::FSE_IDX_ERR_IRQ_EN;
   localparam logic [7:0] ST = fse_pkg::FSE_IDX_CMD_STATUS;
   localparam logic [7:0] ECC = fse_pkg::FSE_IDX_ECC_STATUS;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [1:0] done_st = 2'h0;
   logic seq_req = 1'b0;
   logic [9:0] ev = 10'h000;
   logic [31:0] prdata;
   logic pready, pslverr, cmd_launch, seq_start_ok, command_irq, error_irq;
   logic [31:0] exp_q[$];
   logic [31:0] seed = 32'h3d8307b6;
   logic [7:0] m, s;
   int err_count = 0;
   int tests_run = 0;
   // Fields: cfg, enables, events, expected flags, expected irq.
   logic [23:0] tab [8] = '{24'h001311, 24'h000310, 24'h002521,
      24'h001520, 24'h000930, 24'h003721, 24'h101300, 24'h022121};
   fse_status_regs dut (.sys_clk(sys_clk), .reset(reset), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmd_done(ev[4]), .cmd_done_status(done_st), .seq_violation(ev[5]),
      .illegal_cmd(ev[6]), .prot_violation(ev[7]),
      .seq_start_req(seq_req), .reset_seq_done(ev[8]),
      .reset_seq_double_fault(ev[9]), .array_read(ev[0]),
      .ecc_single_fault(ev[1]), .ecc_double_fault(ev[2]),
      .read_collision(ev[3]), .cmd_launch(cmd_launch),
      .seq_start_ok(seq_start_ok), .command_irq(command_irq),
      .error_irq(error_irq));
   // ***************************************************************
   // Helpers
   // ***************************************************************
   initial forever #50 sys_clk = ~sys_clk;
   task automatic test_done;
      if (err_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // The request stands until pready is seen high, for at most 20 cycles.
   task automatic xfer(input logic [7:0] idx, input logic w,
         input logic [7:0] d);
      int n;
      @(posedge sys_clk);
      paddr <= {2'h0, idx, 2'h0};
      pwrite <= w;
      pwdata <= {24'h0, d};
      psel <= 1'b1;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         err_count++;
         test_done();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(idx, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      xfer(idx, 1'b0, 8'h00);
   endtask
   task automatic pulse(input logic [9:0] v);
      @(posedge sys_clk);
      ev <= v;
      @(posedge sys_clk);
      ev <= 10'h000;
   endtask
   task automatic irq(input logic c, input logic e);
      @(negedge sys_clk);
      chk({31'h0, command_irq}, {31'h0, c});
      chk({31'h0, error_irq}, {31'h0, e});
   endtask
   // Read data is taken at the same edge that samples pready.
   always @(posedge sys_clk)
   begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
         chk(prdata, exp_q.pop_front());
   end
   initial
   begin
      #(100 * 50000);
      err_count++;
      test_done();
   end
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   initial
   begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      rd(CFG, 8'h00);
      rd(EN, 8'h00);
      rd(ST, 8'h80);
      rd(ECC, 8'h00);
      rd(8'h3f, 8'h00);
      irq(1'b0, 1'b0);
      repeat (4)
      begin
         seed = xs(seed);
         wr(EN, seed[7:0]);
         rd(EN, seed[7:0] & 8'h03);
      end
      pstrb <= 4'h0;
      wr(EN, ~seed[7:0]);
      pstrb <= 4'hf;
      rd(EN, seed[7:0] & 8'h03);
      pulse(10'h300);
      rd(ST, 8'h83);
      wr(ST, 8'h80);
      rd(ST, 8'h08);
      wr(ST, 8'h0f);
      rd(ST, 8'h08);
      done_st <= seed[9:8];
      pulse(10'h010);
      s = {6'h20, seed[9:8]};
      rd(ST, s);
      wr(CFG, 8'h80);
      irq(1'b1, 1'b0);
      wr(CFG, 8'h00);
      for (int i = 5; i < 8; i++)
      begin
         m = (i == 7) ? 8'h10 : 8'h20;
         seq_req <= 1'b1;
         pulse(10'h001 << i);
         @(negedge sys_clk);
         chk({31'h0, seq_start_ok}, {31'h0, i != 7});
         rd(ST, s | m);
         wr(ST, 8'h80);
         rd(ST, s | m);
         wr(ST, 8'h00);
         rd(ST, s | m);
         wr(ST, m);
         rd(ST, s);
      end
      foreach (tab[k])
      begin
         wr(CFG, tab[k][23:16]);
         wr(EN, {4'h0, tab[k][15:12]});
         pulse({6'h00, tab[k][11:8]});
         wr(ECC, 8'h00);
         rd(ECC, {4'h0, tab[k][7:4]});
         irq(1'b0, tab[k][0]);
         wr(ECC, 8'h03);
         rd(ECC, 8'h00);
      end
      wr(CFG, 8'h00);
      fork
         wr(ECC, 8'h01);
         begin
            repeat (2) @(posedge sys_clk);
            ev <= 10'h003;
            @(posedge sys_clk);
            ev <= 10'h000;
         end
      join
      rd(ECC, 8'h01);
      test_done();
   end
endmodule
